// ---- common/converter_defines.vh ----
`ifndef CONVERTER_DEFINES_VH
`define CONVERTER_DEFINES_VH
// ----------------------------------------
// register addresses (byte offsets)
// ----------------------------------------
`define ADDR_CTRL 8'h93
`define ADDR_RES_LO 8'h94
`define ADDR_RES_HI 8'h95
`define ADDR_CTRL_B 8'h96
`define ADDR_THRESH 8'h97
`define ADDR_IRQ 8'h98
// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_PD_BIT 7
`define CTRL_MODE_HI 5
`define CTRL_MODE_LO 4
`define CTRL_REF_BIT 3
`define CTRL_RUN_BIT 2
`define CTRL_SEL_HI 1
`define CTRL_SEL_LO 0
`define CTRL_RESET 8'h80
// control b: irq enable, irq flag, clock mode, divider
`define CTRLB_IE_BIT 7
`define CTRLB_IF_BIT 6
`define CTRLB_CLOCK_SOURCE_MODE_BIT 3
`define CTRLB_DIV_HI 2
`define CTRLB_DIV_LO 0
// shared irq register: enable bit 1, flag bit 0
`define IRQ_SIE_BIT 1
`define IRQ_SIF_BIT 0
// ----------------------------------------
// modes and selections
// ----------------------------------------
`define MODE_SINGLE 2'b00
`define MODE_CONT 2'b01
`define MODE_STOP 2'b10
`define MODE_RESET 2'b11
`define SEL_FIRST 2'h0
`define SEL_SECOND 2'h1
`define SEL_THIRD 2'h2
`define SEL_EXTREF 2'h3
// ----------------------------------------
// timing
// ----------------------------------------
`define CONV_CYCLES 4'd11
`define RESULT_MAX 10'h3ff
`define SYSRST_CYCLES 8'h10
`endif

// ---- hdl/conv_clock_gen.v ----
`timescale 1ns/1ps
`include "converter_defines.vh"
// converter clock: synchronised 32 kHz edge or divided system clock, as tick
module conv_clock_gen #(
  parameter DIV_W = 3
) (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire slow_clk_in,
  input wire clock_source_mode_in,
  input wire [DIV_W-1:0] converter_clock_divider_in,
  output reg tick_out,
  output reg half_out
);
  reg s1_q, s2_q, s3_q;
  reg [7:0] cnt_q;
  wire [7:0] limit;
  // divider: 2^(div+1) system clocks per converter clock
  assign limit = (8'h02 << converter_clock_divider_in) - 8'h01;
  // ----------------------------------------
  // synchronise slow clock, count divider
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      cnt_q <= 8'h00;
      tick_out <= 1'b0;
      half_out <= 1'b0;
    end else begin
      s1_q <= slow_clk_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (clock_source_mode_in) begin
        tick_out <= s2_q & ~s3_q;
        half_out <= ~s2_q & s3_q;
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= (cnt_q >= limit) ? 8'h00 : cnt_q + 8'h01;
        tick_out <= (cnt_q >= limit);
        half_out <= (cnt_q == (limit >> 1));
      end
    end
  end
endmodule // conv_clock_gen

// ---- hdl/result_store.v ----
`timescale 1ns/1ps
`include "converter_defines.vh"
// result holder; deliberately ignores system reset so value survives it
module result_store (
  input wire clk_sys_in,
  input wire wr_in,
  input wire [9:0] data_in,
  input wire lo_rd_in,
  output reg [7:0] low_out,
  output reg [1:0] high_out
);
  reg [1:0] hi_raw_q;
  // ----------------------------------------
  // capture; high bits latched on low-byte read
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    if (wr_in) begin
      low_out <= data_in[7:0];
      hi_raw_q <= data_in[9:8];
    end
    if (lo_rd_in) begin
      high_out <= wr_in ? data_in[9:8] : hi_raw_q;
    end
  end
endmodule // result_store

// ---- hdl/adc_conversion_sequencer.v ----
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "converter_defines.vh"
// How it works
// - result is unsigned 10 bits, 0 is 0 V, 1023 is reference.
// - input select picks one of three pins, or pin one with external reference.
// - reference bit picks supply or internal 1.25 V full scale.
// - each conversion lasts exactly 11 converter clocks.
// - clock mode 1 drives the converter from the 32 kHz clock.
// - clock mode 0 divides the system clock; software keeps it <= 250 kHz.
// - single mode: run bit starts one conversion, hardware clears it after.
// - outside reset mode, sample top 8 bits >= threshold sets shared and converter flags.
// - service request only when both enables are set.
// - multi modes start a new conversion every 11th converter clock.
// - clearing run in multi mode abandons conversion and stops.
// - continuous mode flags on match and keeps converting.
// - stopping mode flags on match, halts, clears run bit.
// - reset-generating mode asserts system reset instead of interrupt.
// - result registers keep contents through system reset.
// - input sampled for one half converter clock period per conversion.
// - mode field 00 single, 01 continuous, 10 stopping, 11 reset.
// - select 00/01/10 pins, 11 first pin with second as reference.
// - high result bits captured when low byte is read.
// - power-down bit resets to 1.
module adc_conversion_sequencer #(
  parameter DIV_W = 3
) (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire slow_clk_in,
  input wire [9:0] afe_result_in,
  output reg afe_power_down_out,
  output reg [1:0] afe_input_sel_out,
  output reg [1:0] afe_ref_sel_out,
  output reg afe_sample_out,
  output reg afe_convert_out,
  output reg irq_request_out,
  output reg system_reset_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam S_IDLE = 2'b01;
  localparam S_CONV = 2'b10;
  reg [1:0] state_q;
  reg pd_q, ref_q, run_q, sie_q, sif_q, cie_q, cif_q, clock_source_mode_q;
  reg [1:0] mode_q, sel_q;
  reg [DIV_W-1:0] div_q;
  reg [7:0] thresh_q;
  reg [3:0] cyc_q;
  reg [7:0] rst_cnt_q;
  reg [9:0] res_q;
  reg done_q;
  reg [9:0] sync1_q;
  // second stage: the front end word settles on its own timing, not ours
  reg [9:0] sync2_q;
  wire tick, half_tick, last_cycle, match, lo_rd, res_wr;
  // high for the one tick that opens a conversion, first or follow-on
  wire start_conv;
  // divider field as read back; the field is three bits wide
  wire [2:0] div_rd;
  wire [7:0] res_low;
  wire [1:0] res_high;
  wire [7:0] ctrl_rd, ctrlb_rd, irq_rd;
  // ----------------------------------------
  // converter clock and result holder
  // ----------------------------------------
  conv_clock_gen #(.DIV_W(DIV_W)) u_clk (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .slow_clk_in(slow_clk_in),
    .clock_source_mode_in(clock_source_mode_q),
    .converter_clock_divider_in(div_q),
    .tick_out(tick),
    .half_out(half_tick)
  );
  assign lo_rd = rd_in && (addr_in == `ADDR_RES_LO);
  assign res_wr = done_q;
  result_store u_res (
    .clk_sys_in(clk_sys_in),
    .wr_in(res_wr),
    .data_in(res_q),
    .lo_rd_in(lo_rd),
    .low_out(res_low),
    .high_out(res_high)
  );
  // compare after the result write, on the stored sample
  assign match = done_q && (res_q[9:2] >= thresh_q);
  // the opening tick counts as cycle one, so the eleventh tick after it closes it
  assign last_cycle = tick && (cyc_q == `CONV_CYCLES);
  // a closing tick in a multi mode opens the next conversion at once
  assign start_conv = tick && run_q && !pd_q &&
    ((state_q == S_IDLE) ||
     ((state_q == S_CONV) && (cyc_q == `CONV_CYCLES) && (mode_q != `MODE_SINGLE)));
  // ----------------------------------------
  // read mux
  // ----------------------------------------
  assign ctrl_rd = {pd_q, 1'b0, mode_q, ref_q, run_q, sel_q};
  // divider read back through a fixed three-bit field
  assign div_rd = div_q[2:0];
  assign ctrlb_rd = {cie_q, cif_q, 2'b00, clock_source_mode_q, div_rd};
  assign irq_rd = {6'h00, sie_q, sif_q};
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `ADDR_CTRL: rdata_out <= ctrl_rd;
        `ADDR_RES_LO: rdata_out <= res_low;
        `ADDR_RES_HI: rdata_out <= {6'h00, lo_rd ? res_q[9:8] : res_high};
        `ADDR_CTRL_B: rdata_out <= ctrlb_rd;
        `ADDR_THRESH: rdata_out <= thresh_q;
        `ADDR_IRQ: rdata_out <= irq_rd;
        default: rdata_out <= 8'h00; // unmapped reads zero
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end
  // ----------------------------------------
  // registers, sequencer, flags
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      pd_q <= 1'b1;
      mode_q <= `MODE_SINGLE;
      ref_q <= 1'b0;
      run_q <= 1'b0;
      sel_q <= `SEL_FIRST;
      cie_q <= 1'b0;
      cif_q <= 1'b0;
      sie_q <= 1'b0;
      sif_q <= 1'b0;
      clock_source_mode_q <= 1'b0;
      div_q <= {DIV_W{1'b0}};
      thresh_q <= 8'h00;
      state_q <= S_IDLE;
      cyc_q <= 4'd0;
      done_q <= 1'b0;
      res_q <= 10'h000;
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end else begin
      done_q <= 1'b0;
      // analog result crosses from the front end, two stages
      sync1_q <= afe_result_in;
      sync2_q <= sync1_q;
      // software writes; hardware sets below take priority
      if (wr_in) begin
        case (addr_in)
          `ADDR_CTRL: begin
            pd_q <= wdata_in[`CTRL_PD_BIT];
            mode_q <= wdata_in[`CTRL_MODE_HI:`CTRL_MODE_LO];
            ref_q <= wdata_in[`CTRL_REF_BIT];
            run_q <= wdata_in[`CTRL_RUN_BIT];
            sel_q <= wdata_in[`CTRL_SEL_HI:`CTRL_SEL_LO];
          end
          `ADDR_CTRL_B: begin
            cie_q <= wdata_in[`CTRLB_IE_BIT];
            cif_q <= wdata_in[`CTRLB_IF_BIT];
            clock_source_mode_q <= wdata_in[`CTRLB_CLOCK_SOURCE_MODE_BIT];
            div_q <= wdata_in[DIV_W-1:0];
          end
          `ADDR_THRESH: thresh_q <= wdata_in;
          `ADDR_IRQ: begin
            sie_q <= wdata_in[`IRQ_SIE_BIT];
            sif_q <= wdata_in[`IRQ_SIF_BIT];
          end
          default: ;
        endcase
      end
      // sequencer; software keeps power-up wait before run
      case (state_q)
        S_IDLE: begin
          cyc_q <= 4'd0;
          if (run_q && !pd_q && tick) begin
            state_q <= S_CONV;
            cyc_q <= 4'd1;
          end
        end
        S_CONV: begin
          if (!run_q || pd_q) begin
            state_q <= S_IDLE;
            cyc_q <= 4'd0;
          end else if (last_cycle) begin
            res_q <= sync2_q;
            done_q <= 1'b1;
            // in multi modes the closing tick is cycle one of the next conversion; single mode goes back to 0
            cyc_q <= (mode_q == `MODE_SINGLE) ? 4'd0 : 4'd1;
            if (mode_q == `MODE_SINGLE) begin
              run_q <= 1'b0;
              state_q <= S_IDLE;
            end
          end else if (tick) begin
            cyc_q <= cyc_q + 4'd1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
      // threshold action by mode; set wins over a same-cycle clear
      if (match) begin
        if (mode_q != `MODE_RESET) begin
          sif_q <= 1'b1;
          cif_q <= 1'b1;
        end
        if (mode_q == `MODE_STOP) begin
          run_q <= 1'b0;
          state_q <= S_IDLE;
        end
      end
    end
  end
  // ----------------------------------------
  // system reset pulse, front end and irq outputs
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rst_cnt_q <= 8'h00;
      system_reset_out <= 1'b0;
      irq_request_out <= 1'b0;
      afe_power_down_out <= 1'b1;
      afe_input_sel_out <= `SEL_FIRST;
      afe_ref_sel_out <= 2'b00;
      afe_sample_out <= 1'b0;
      afe_convert_out <= 1'b0;
    end else begin
      if (match && mode_q == `MODE_RESET)
        rst_cnt_q <= `SYSRST_CYCLES;
      else if (rst_cnt_q != 8'h00)
        rst_cnt_q <= rst_cnt_q - 8'h01;
      system_reset_out <= (rst_cnt_q != 8'h00);
      irq_request_out <= sif_q && sie_q && cif_q && cie_q;
      afe_power_down_out <= pd_q;
      // select 11 is first pin with second as reference
      afe_input_sel_out <= (sel_q == `SEL_EXTREF) ? `SEL_FIRST : sel_q;
      // ref code: 00 supply, 01 internal, 10 external pin
      afe_ref_sel_out <= (sel_q == `SEL_EXTREF) ? 2'b10 : {1'b0, ref_q};
      // sample during the first half clock of each conversion
      // opened by the starting tick, closed by the half tick after it
      // follow-on conversions keep busy high, so busy cannot gate this
      if (start_conv)
        afe_sample_out <= 1'b1;
      else if (half_tick || state_q != S_CONV)
        afe_sample_out <= 1'b0;
      afe_convert_out <= (state_q == S_CONV);
    end
  end
endmodule // adc_conversion_sequencer

// ---- bench/adc_seq_chk_sva.sv ----
`timescale 1ns/1ps
`include "converter_defines.vh"
module adc_seq_chk (
  input logic clk_sys_in,
  input logic nrst_in,
  input logic [7:0] addr_in,
  input logic [7:0] wdata_in,
  input logic wr_in,
  input logic rd_in,
  input logic [7:0] rdata_out,
  input logic afe_power_down_out,
  input logic [1:0] afe_input_sel_out,
  input logic [1:0] afe_ref_sel_out,
  input logic afe_convert_out,
  input logic irq_request_out,
  input logic system_reset_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  logic [7:0] pulse_q;
  logic [7:0] w_q;
  // width of the running reset pulse
  always_ff @(posedge clk_sys_in)
    if (!nrst_in || !system_reset_out) pulse_q <= 8'h00;
    else pulse_q <= pulse_q + 8'h01;
  // last control byte written
  always_ff @(posedge clk_sys_in)
    if (wr_in && addr_in == `ADDR_CTRL) w_q <= wdata_in;
  sequence s_ctrl_wr;
    wr_in && addr_in == `ADDR_CTRL;
  endsequence
  sequence s_boot_rd;
    $rose(nrst_in) ##1 (rd_in && addr_in == `ADDR_CTRL);
  endsequence
  // reset itself is the cause here, so it must not disable the check
  property p_pd_rst;
    disable iff (1'b0) !nrst_in |=> afe_power_down_out;
  endproperty
  property p_boot_rd;
    s_boot_rd |=> rdata_out == `CTRL_RESET;
  endproperty
  property p_rd_idle;
    !rd_in |=> rdata_out == 8'h00;
  endproperty
  property p_unmapped;
    rd_in && addr_in == 8'h00 |=> rdata_out == 8'h00;
  endproperty
  property p_hi_upper;
    rd_in && addr_in == `ADDR_RES_HI |=> rdata_out[7:2] == 6'h00;
  endproperty
  property p_mux;
    s_ctrl_wr |-> ##2 (afe_power_down_out == w_q[7] && afe_input_sel_out ==
      (&w_q[1:0] ? 2'b00 : w_q[1:0]) && afe_ref_sel_out == (&w_q[1:0] ? 2'b10 : {1'b0, w_q[3]}));
  endproperty
  property p_pulse;
    $fell(system_reset_out) |-> pulse_q == `SYSRST_CYCLES;
  endproperty
  property p_irq_off;
    wr_in && addr_in == `ADDR_IRQ && !wdata_in[`IRQ_SIE_BIT] |-> ##2 !irq_request_out;
  endproperty
  property p_abandon;
    wr_in && addr_in == `ADDR_CTRL && !wdata_in[`CTRL_RUN_BIT] && afe_convert_out
      |-> ##[1:3] !afe_convert_out;
  endproperty
  a_pd_rst: assert property (p_pd_rst) else $error("power down not set by reset");
  a_boot_rd: assert property (p_boot_rd) else $error("control reset value wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_hi_upper: assert property (p_hi_upper) else $error("high result byte too wide");
  a_mux: assert property (p_mux) else $error("input or reference routing wrong");
  a_pulse: assert property (p_pulse) else $error("system reset pulse length wrong");
  a_irq_off: assert property (p_irq_off) else $error("request with enable clear");
  a_abandon: assert property (p_abandon) else $error("conversion not abandoned");
endmodule // adc_seq_chk

// ---- bench/afe_model.sv ----
`timescale 1ns/1ps
module afe_model (
  input logic clk_sys_in,
  input logic power_down_in,
  input logic [1:0] input_sel_in,
  input logic sample_in,
  input logic [9:0] level_in,
  output logic [9:0] result_out
);
  initial result_out = 10'h155;
  // powered down the output is meaningless, so keep it moving
  always @(posedge clk_sys_in)
    if (power_down_in) result_out <= ~result_out;
    else if (sample_in) result_out <= level_in ^ {8'h00, input_sel_in};
endmodule // afe_model

// ---- bench/adc_conversion_sequencer_tb.sv ----
`timescale 1ns/1ps
`include "converter_defines.vh"
module adc_conversion_sequencer_tb;
  logic clk_sys_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, slow_clk_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, v;
  logic [9:0] afe_result_in, level = 10'h2a5;
  logic afe_power_down_out, afe_sample_out, afe_convert_out, irq_request_out, system_reset_out;
  logic [1:0] afe_input_sel_out, afe_ref_sel_out;
  int num_errors = 0, samples_checked = 0, n, h;
  initial forever #4 clk_sys_in = ~clk_sys_in;
  // slow clock shortened to keep the run brief
  initial forever #100 slow_clk_in = ~slow_clk_in;
  adc_conversion_sequencer #(.DIV_W(3)) uut (.*);
  afe_model far (.clk_sys_in(clk_sys_in), .power_down_in(afe_power_down_out),
    .input_sel_in(afe_input_sel_out), .sample_in(afe_sample_out), .level_in(level),
    .result_out(afe_result_in));
  // ----
  // helpers
  // ----
  task conclude;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task stuck(input logic bad);
    if (bad) begin
      num_errors++;
      $display("BAD %0t wait ran out", $time);
      conclude;
    end
  endtask
  // busy length of the next conversion
  task conv(output int len);
    int i;
    for (i = 0; i < 3000 && !afe_convert_out; i++) @(negedge clk_sys_in);
    for (len = 0; len < 3000 && afe_convert_out; len++) @(negedge clk_sys_in);
    stuck(len == 0 || afe_convert_out);
  endtask
  // sample pulse width and sample period
  task gap(output int hi, output int per);
    int i;
    for (i = 0; i < 3000 && !afe_sample_out; i++) @(negedge clk_sys_in);
    for (hi = 0; hi < 3000 && afe_sample_out; hi++) @(negedge clk_sys_in);
    for (per = hi; per < 3000 && !afe_sample_out; per++) @(negedge clk_sys_in);
    stuck(per >= 3000);
  endtask
  // ----
  // scenarios
  // ----
  task t_single;
    rd(`ADDR_CTRL);
    chk(v, `CTRL_RESET);
    rd(8'h00);
    chk(v, 8'h00);
    wr(`ADDR_CTRL_B, 8'h80);
    wr(`ADDR_IRQ, 8'h02);
    wr(`ADDR_THRESH, 8'ha9);
    wr(`ADDR_CTRL, 8'h01);
    repeat (625) @(posedge clk_sys_in);
    wr(`ADDR_CTRL, 8'h05);
    conv(n);
    chk(n[9:0], 10'd22);
    rd(`ADDR_CTRL);
    chk(v, 8'h01);
    rd(`ADDR_RES_LO);
    chk(v, 8'ha4);
    rd(`ADDR_RES_HI);
    chk(v, 8'h02);
    chk(irq_request_out, 1'b1);
    wr(`ADDR_CTRL_B, 8'h40);
    rd(`ADDR_IRQ);
    chk(v[0], 1'b1);
    chk(irq_request_out, 1'b0);
    wr(`ADDR_IRQ, 8'h00);
  endtask
  task t_cont;
    wr(`ADDR_CTRL_B, 8'h01);
    wr(`ADDR_THRESH, 8'hff);
    wr(`ADDR_CTRL, 8'h15);
    gap(h, n);
    chk(h[9:0], 10'd2);
    chk(n[9:0], 10'd44);
    wr(`ADDR_THRESH, 8'h00);
    gap(h, n);
    gap(h, n);
    chk(n[9:0], 10'd44);
    rd(`ADDR_CTRL_B);
    chk(v[6], 1'b1);
    wr(`ADDR_CTRL, 8'h11);
    repeat (100) @(negedge clk_sys_in);
    chk(afe_convert_out, 1'b0);
    wr(`ADDR_IRQ, 8'h02);
    wr(`ADDR_CTRL_B, 8'h80);
  endtask
  task t_stop;
    wr(`ADDR_CTRL, 8'h25);
    conv(n);
    rd(`ADDR_CTRL);
    chk(v, 8'h21);
    rd(`ADDR_CTRL_B);
    chk(v[6], 1'b1);
    repeat (60) @(negedge clk_sys_in);
    chk(afe_convert_out, 1'b0);
    wr(`ADDR_CTRL_B, 8'h80);
  endtask
  task t_sysrst;
    level = 10'h13c;
    wr(`ADDR_CTRL, 8'h35);
    for (n = 0; n < 3000 && !system_reset_out; n++) @(negedge clk_sys_in);
    stuck(n >= 3000);
    chk(irq_request_out, 1'b0);
    repeat (20) @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd(`ADDR_RES_LO);
    chk(v, 8'h3d);
    rd(`ADDR_RES_HI);
    chk(v, 8'h01);
  endtask
  task t_slow;
    wr(`ADDR_CTRL_B, 8'h08);
    wr(`ADDR_CTRL, 8'h03);
    repeat (625) @(posedge clk_sys_in);
    wr(`ADDR_CTRL, 8'h07);
    conv(n);
    chk(n >= 250 && n <= 300, 1'b1);
    rd(`ADDR_RES_LO);
    chk(v, 8'h3c);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    t_single;
    t_cont;
    t_stop;
    t_sysrst;
    t_slow;
    conclude;
  end
endmodule // adc_conversion_sequencer_tb
bind adc_conversion_sequencer adc_seq_chk chk (.*);
